// File: ces_pkg.sv
/*
  ces_pkg: constants, register layout, types and states of the converter
  enable and fault sequencer.
  assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package ces_pkg;

  // timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RESTART_MS      = 100;
  localparam int unsigned HICCUP_MS       = 50;
  localparam int unsigned RESTART_CYC_DEF = CLK_HZ / 1000 * RESTART_MS;
  localparam int unsigned HICCUP_CYC_DEF  = CLK_HZ / 1000 * HICCUP_MS;

  // register byte addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_ENCFG = 8'h04;
  localparam logic [7:0] A_TLIM  = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;

  // reset values: on-command set, primary honoured active low, secondary ignored
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [31:0] ENCFG_RST = 32'h0000_0004;
  localparam logic [31:0] TLIM_RST  = 32'h0000_0A7D;
  localparam logic [31:0] ZERO32    = 32'h0000_0000;
  localparam int unsigned CTRL_OP_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // enable-pin configuration (primary_enable_config_cmd in low pair)
  typedef struct packed {
    logic pol2;  // 1: active high
    logic ign2;
    logic pol1;
    logic ign1;
  } ces_encfg_t;

  // temperature limits and fault responses (1 = ignore fault)
  typedef struct packed {
    logic [5:0] rsv;
    logic       cold_ign;
    logic       hot_ign;
    logic [7:0] cold_lim;
    logic [7:0] hys;
    logic [7:0] hot_lim;
  } ces_tlim_t;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_DELAY = 5'h02,
    ST_SOFT  = 5'h04,
    ST_RUN   = 5'h08,
    ST_HICC  = 5'h10
  } ces_state_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic        uv_lock;
    logic        cold_lock;
    logic        hot_lock;
    logic        en_ok;
    logic        en2_ok;
    logic        en1_ok;
    ces_state_t  state;
  } ces_stat_t;

endpackage

// File: ces_top.sv
/*
  ces_top: decides when the converter output stage runs. two enable pins with
  polarity and ignore options, a host on-command, thermal, short-circuit,
  overvoltage shutdown with hiccup restart, and input undervoltage shutdown with delayed restart.
  assumes all inputs synchronous to i_clk; analog comparators outside.
*/
// Summary of operation
// - temperature above hot limit shuts the power stage down.
// - thermal restart only once temperature drops below limit minus hysteresis.
// - hot limit and hysteresis are host-writable registers.
// - hot and cold limits with selectable fault response are host-writable.
// - short-circuit peak current switches the modulator drive off at once.
// - after current fault and hiccup wait, run full start including soft start.
// - hiccup cycle repeats without limit; normal running resumes when fault clears.
// - active-low enable: low means on, open or high means off.
// - active-high enable: open or high means on, low means off.
// - enable pin on or off applies a 100 ms restart delay.
// - primary enable configurable; honoured by default, must be asserted.
// - secondary enable configurable; ignored by default, treated as on.
// - an ignored enable reads on for any level and polarity.
// - output runs only when both enable results and on-command are on.
// - overvoltage at output power pins shuts the output down.
// - thermal recovery uses only hiccup restart with configurable hysteresis.
// - after input undervoltage, restart waits until input exceeds start threshold.
`timescale 1ns/1ps
module ces_top
  import ces_pkg::*;
#(
  parameter int unsigned RESTART_CYC = RESTART_CYC_DEF,
  parameter int unsigned HICCUP_CYC  = HICCUP_CYC_DEF
) (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // analog and pin inputs
  input  wire logic [7:0]  i_temp,
  input  wire logic        i_peak_short,
  input  wire logic        i_ovp_pins,
  input  wire logic        i_vin_above_start,
  input  wire logic        i_vin_below_uv,
  input  wire logic        i_en1_pin,
  input  wire logic        i_en2_pin,
  input  wire logic        i_soft_done,
  // power stage control
  output logic             o_drive_en,
  output logic             o_soft_start,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    sat_sub = (a > b) ? a - b : 8'h00;
  endfunction

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction

  // register file and bus state
  logic [31:0] ctrl_r, ctrl_nxt, encfg_r, encfg_nxt, tlim_r, tlim_nxt;
  logic        awr_r, awr_nxt, bval_r, bval_nxt, arr_r, arr_nxt, rval_r, rval_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  ces_encfg_t  ecfg;
  ces_tlim_t   tcfg;
  ces_stat_t   stat;
  logic        wr_fire, rd_fire;

  // sequencer state
  ces_state_t  st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic        hot_r, hot_nxt, cold_r, cold_nxt, uv_r, uv_nxt;
  logic        drv_r, drv_nxt, soft_r, soft_nxt;
  logic        en1_ok, en2_ok, en_ok, hot_trip, cold_trip, fault, allow;

  assign ecfg    = ces_encfg_t'(encfg_r[3:0]);
  assign tcfg    = ces_tlim_t'(tlim_r);
  assign wr_fire = s_axi_awvalid & awr_r & s_axi_wvalid;
  assign rd_fire = s_axi_arvalid & arr_r;

  // enable evaluation
  assign en1_ok = ecfg.ign1 | (ecfg.pol1 ? i_en1_pin : ~i_en1_pin);
  assign en2_ok = ecfg.ign2 | (ecfg.pol2 ? i_en2_pin : ~i_en2_pin);
  assign en_ok  = en1_ok & en2_ok & ctrl_r[CTRL_OP_BIT];

  assign hot_trip  = (i_temp > tcfg.hot_lim) & ~tcfg.hot_ign;
  assign cold_trip = (i_temp < tcfg.cold_lim) & ~tcfg.cold_ign;
  assign fault     = i_peak_short | i_ovp_pins | hot_trip | cold_trip;
  // a trip in this very cycle must also block a start, not only the registered lock
  assign allow     = en_ok & ~hot_r & ~cold_r & ~hot_trip & ~cold_trip & ~uv_r & ~uv_nxt;

  always_comb begin
    stat           = '0;
    stat.state     = st_r;
    stat.en1_ok    = en1_ok;
    stat.en2_ok    = en2_ok;
    stat.en_ok     = en_ok;
    stat.hot_lock  = hot_r;
    stat.cold_lock = cold_r;
    stat.uv_lock   = uv_r;
  end

  // register bus: write and read each take one request at a time
  always_comb begin
    ctrl_nxt  = ctrl_r;
    encfg_nxt = encfg_r;
    tlim_nxt  = tlim_r;
    awr_nxt   = 1'b0;
    bval_nxt  = bval_r & ~s_axi_bready;
    bresp_nxt = bresp_r;
    arr_nxt   = 1'b0;
    rval_nxt  = rval_r & ~s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && s_axi_wvalid && !awr_r && !bval_r) begin
      awr_nxt = 1'b1;
    end
    if (wr_fire) begin
      bval_nxt  = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (s_axi_awaddr)
        A_CTRL:  ctrl_nxt  = merge(ctrl_r, s_axi_wdata, s_axi_wstrb);
        A_ENCFG: encfg_nxt = merge(encfg_r, s_axi_wdata, s_axi_wstrb) & 32'h0000_000F;
        A_TLIM:  tlim_nxt  = merge(tlim_r, s_axi_wdata, s_axi_wstrb) & 32'h03FF_FFFF;
        A_STAT:  bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !arr_r && !rval_r) begin
      arr_nxt = 1'b1;
    end
    if (rd_fire) begin
      rval_nxt  = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (s_axi_araddr)
        A_CTRL:  rdata_nxt = ctrl_r;
        A_ENCFG: rdata_nxt = encfg_r;
        A_TLIM:  rdata_nxt = tlim_r;
        A_STAT:  rdata_nxt = stat;
        default: begin
          rdata_nxt = ZERO32;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // sequencer
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    hot_nxt  = hot_r;
    cold_nxt = cold_r;
    uv_nxt   = uv_r;
    // set wins over the recovery clear on every lock
    if (i_temp < sat_sub(tcfg.hot_lim, tcfg.hys)) hot_nxt = 1'b0;
    if (i_temp > sat_add(tcfg.cold_lim, tcfg.hys)) cold_nxt = 1'b0;
    if (hot_trip) hot_nxt = 1'b1;
    if (cold_trip) cold_nxt = 1'b1;
    if (i_vin_above_start) uv_nxt = 1'b0;
    if (i_vin_below_uv) uv_nxt = 1'b1;
    unique case (st_r)
      ST_OFF: begin
        // off dwell also counts so a quick re-enable still sees the delay
        if (cnt_r < RESTART_CYC - 1) cnt_nxt = cnt_r + 32'h0000_0001;
        if (allow && cnt_r >= RESTART_CYC - 1) begin
          st_nxt  = ST_DELAY;
          cnt_nxt = ZERO32;
        end
      end
      ST_DELAY: begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (!allow) begin
          st_nxt  = ST_OFF;
          cnt_nxt = ZERO32;
        end else if (cnt_r >= RESTART_CYC - 1) begin
          st_nxt  = ST_SOFT;
          cnt_nxt = ZERO32;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (fault) begin
          st_nxt  = ST_HICC;
          cnt_nxt = ZERO32;
        end else if (!en_ok || uv_nxt) begin
          st_nxt  = ST_OFF;
          cnt_nxt = ZERO32;
        end else if (st_r == ST_SOFT && i_soft_done) begin
          st_nxt = ST_RUN;
        end
      end
      ST_HICC: begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        if (cnt_r >= HICCUP_CYC - 1) begin
          cnt_nxt = ZERO32;
          if (hot_r || cold_r || hot_trip || cold_trip) st_nxt = ST_HICC;
          else if (allow) st_nxt = ST_SOFT;
          else st_nxt = ST_OFF;
        end
      end
    endcase
    drv_nxt  = (st_nxt == ST_SOFT) || (st_nxt == ST_RUN);
    soft_nxt = (st_nxt == ST_SOFT);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_r  <= CTRL_RST;
      encfg_r <= ENCFG_RST;
      tlim_r  <= TLIM_RST;
      awr_r   <= 1'b0;
      bval_r  <= 1'b0;
      bresp_r <= RESP_OKAY;
      arr_r   <= 1'b0;
      rval_r  <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= ZERO32;
      st_r    <= ST_OFF;
      cnt_r   <= ZERO32;
      hot_r   <= 1'b0;
      cold_r  <= 1'b0;
      uv_r    <= 1'b1;
      drv_r   <= 1'b0;
      soft_r  <= 1'b0;
    end else if (i_ce) begin
      ctrl_r  <= ctrl_nxt;
      encfg_r <= encfg_nxt;
      tlim_r  <= tlim_nxt;
      awr_r   <= awr_nxt;
      bval_r  <= bval_nxt;
      bresp_r <= bresp_nxt;
      arr_r   <= arr_nxt;
      rval_r  <= rval_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      hot_r   <= hot_nxt;
      cold_r  <= cold_nxt;
      uv_r    <= uv_nxt;
      drv_r   <= drv_nxt;
      soft_r  <= soft_nxt;
    end
  end

  assign o_drive_en    = drv_r;
  assign o_soft_start  = soft_r;
  assign s_axi_awready = awr_r;
  assign s_axi_wready  = awr_r;
  assign s_axi_bvalid  = bval_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rval_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // checks
  property p_short_off;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && i_peak_short && o_drive_en |=> !o_drive_en;
  endproperty
  a_short_off: assert property (p_short_off) else $error("drive stayed on after short");
  // only an output with drive on is shut by overvoltage; off, delay and hiccup states ignore it and keep sequencing
  property p_ovp_off;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && i_ovp_pins && o_drive_en |=> !o_drive_en && st_r == ST_HICC;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("overvoltage did not shut output");
  property p_all_on;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && !en_ok |=> !o_drive_en;
  endproperty
  a_all_on: assert property (p_all_on) else $error("drive on while an enable is off");
  property p_act_low;
    @(posedge i_clk) disable iff (!i_rstn)
    !ecfg.ign1 && !ecfg.pol1 |-> en1_ok == !i_en1_pin;
  endproperty
  a_act_low: assert property (p_act_low) else $error("active-low enable misread");
  property p_ignored;
    @(posedge i_clk) disable iff (!i_rstn)
    ecfg.ign2 |-> en2_ok;
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored enable not on");
  property p_hot_trip;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && i_temp > tcfg.hot_lim && !tcfg.hot_ign |=> hot_r && !o_drive_en;
  endproperty
  a_hot_trip: assert property (p_hot_trip) else $error("no thermal shutdown");
  property p_hot_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && hot_r && i_temp >= sat_sub(tcfg.hot_lim, tcfg.hys) |=> hot_r;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("thermal lock released early");
  property p_uv_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && uv_r && !i_vin_above_start |=> uv_r;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("undervoltage lock released early");
  property p_hicc_restart;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && st_r == ST_HICC && cnt_r >= HICCUP_CYC - 1 && allow && !hot_r && !cold_r
      |=> o_soft_start && o_drive_en;
  endproperty
  a_hicc_restart: assert property (p_hicc_restart) else $error("no soft start after hiccup");
  property p_delay_off;
    @(posedge i_clk) disable iff (!i_rstn)
    i_ce && st_r == ST_DELAY && cnt_r < RESTART_CYC - 1 |=> !o_drive_en;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("drive on inside restart delay");

endmodule // ces_top

// File: ces_host.sv
/*
  ces_host: host controller model, an axi4-lite master that reads and writes
  the sequencer registers as the management bus side would.
  assumes each task is entered right after a rising edge of i_clk.
*/
`timescale 1ns/1ps
module ces_host (
  // clock
  input  wire logic        i_clk,
  // axi4-lite write
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // axi4-lite read
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // outputs are registered, so the level seen at the falling edge is what the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge i_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge i_clk);
      aw = s_axi_awready & s_axi_awvalid;
      w  = s_axi_wready & s_axi_wvalid;
      b  = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge i_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge i_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge i_clk);
      ar = s_axi_arready & s_axi_arvalid;
      v  = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge i_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule // ces_host

// File: tb.sv
/*
  tb: self-checking bench for ces_top with a register model and cycle windows.
  assumes short restart and hiccup counts; the host model drives the bus.
*/
`timescale 1ns/1ps
module tb;
  import ces_pkg::*;
  localparam int RC = 8;
  localparam int HC = 6;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_peak_short = 1'b0, i_ovp_pins = 1'b0;
  logic i_ce = 1'b1;
  logic i_vin_above_start = 1'b0, i_vin_below_uv = 1'b0, i_soft_done = 1'b0;
  logic i_en1_pin = 1'b0, i_en2_pin = 1'b0, o_drive_en, o_soft_start, e1, e2;
  logic [7:0] i_temp = 8'h28, s_axi_awaddr, s_axi_araddr, hot, hys;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors = 0, total_checks = 0, cyc = 0;
  int regs [4];
  int msk [3] = '{32'h0000_0001, 32'h0000_000F, 32'h03FF_FFFF};

  always #25 i_clk = ~i_clk;

  ces_top #(.RESTART_CYC(RC), .HICCUP_CYC(HC)) dut (.i_clk, .i_rstn, .i_ce, .i_temp, .i_peak_short,
    .i_ovp_pins, .i_vin_above_start, .i_vin_below_uv, .i_en1_pin, .i_en2_pin, .i_soft_done, .o_drive_en,
    .o_soft_start, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ces_host host (.i_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // about a twentieth of this is used; a stuck handshake ends here
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude;
    end
  end

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // waits for a level on drive or soft start, then checks the cycle count window
  task automatic tm(input string n, input bit s, input logic lvl, input int mx, input int lo, input int hi);
    int k;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while ((s ? o_soft_start : o_drive_en) !== lvl && k < mx);
    @(posedge i_clk);
    total_checks++;
    if (k < lo || k > hi) begin
      n_errors++;
      $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, k);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
    chk_reg("bresp", (a > A_STAT) ? RESP_SLVERR : RESP_OKAY, r);
    if (a < A_STAT) regs[a[3:2]] = v & msk[a[3:2]];
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] m);
    host.rd(a, d, r);
    chk_reg("rresp", (a > A_STAT) ? RESP_SLVERR : RESP_OKAY, r);
    chk_reg("rdata", (a > A_STAT) ? ZERO32 : regs[a[3:2]] & m, d & m);
  endtask

  initial begin
    void'($urandom(32'hc2f0));
    regs = '{CTRL_RST, ENCFG_RST, TLIM_RST, 32'h0000_04E1};
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    rreg(A_CTRL, '1);
    rreg(A_ENCFG, '1);
    rreg(A_TLIM, '1);
    rreg(A_STAT, 32'h0000_07FF);
    wreg(8'h10, $urandom);
    rreg(8'h10, '1);
    wreg(A_STAT, $urandom);
    $display("test reset and map done");
    for (int k = 0; k < 64; k++) begin
      i_en1_pin <= k[4];
      i_en2_pin <= k[5];
      wreg(A_ENCFG, k);
      e1 = k[0] | (k[4] == k[1]);
      e2 = k[2] | (k[5] == k[3]);
      regs[3] = {e1 & e2, e2, e1, 5'h00};
      rreg(A_STAT, 32'h0000_00E0);
    end
    i_en1_pin <= 1'b0;
    wreg(A_ENCFG, ENCFG_RST);
    hot = 8'h60 + 8'($urandom_range(0, 15));
    hys = 8'h02 + 8'($urandom_range(0, 7));
    wreg(A_TLIM, ($urandom & 32'hFC00_0000) | {16'h0000, hys, hot});
    rreg(A_TLIM, '1);
    $display("test enable table done");
    i_temp <= 8'($urandom_range(20, 60));
    tm("uv hold", 0, 1'b1, 3 * RC, 3 * RC, 3 * RC);
    i_vin_above_start <= 1'b1;
    i_en1_pin <= 1'b1;
    tm("en1 hold", 0, 1'b1, 3 * RC, 3 * RC, 3 * RC);
    i_en1_pin <= 1'b0;
    tm("start", 0, 1'b1, 4 * RC, RC, 2 * RC + 4);
    regs[3] = 32'h0000_0004;
    rreg(A_STAT, 32'h0000_001F);
    i_soft_done <= 1'b1;
    regs[3] = 32'h0000_0008;
    rreg(A_STAT, 32'h0000_001F);
    $display("test start done");
    i_en1_pin <= 1'b1;
    tm("pin off", 0, 1'b0, 3, 2, 2);
    i_en1_pin <= 1'b0;
    tm("pin on", 0, 1'b1, 4 * RC, RC, 2 * RC + 4);
    wreg(A_CTRL, 32'h0000_0000);
    tm("op off", 0, 1'b0, 4, 1, 4);
    wreg(A_CTRL, 32'h0000_0001);
    tm("op on", 0, 1'b1, 4 * RC, RC - 4, 2 * RC + 4);
    $display("test enable control done");
    i_peak_short <= 1'b1;
    tm("short off", 0, 1'b0, 3, 2, 2);
    tm("hiccup wait", 1, 1'b1, 3 * HC, HC - 2, HC + 3);
    tm("retry off", 0, 1'b0, 3, 1, 2);
    tm("retry again", 1, 1'b1, 3 * HC, HC - 2, HC + 3);
    i_peak_short <= 1'b0;
    tm("short clear", 0, 1'b1, 3 * HC, 1, HC + 3);
    tm("run hold", 0, 1'b0, 20, 20, 20);
    i_ce <= 1'b0;
    i_peak_short <= 1'b1;
    tm("ce freeze", 0, 1'b0, 6, 6, 6);
    i_peak_short <= 1'b0;
    i_ce <= 1'b1;
    rreg(A_STAT, 32'h0000_001F);
    i_ovp_pins <= 1'b1;
    tm("ovp off", 0, 1'b0, 3, 2, 2);
    i_ovp_pins <= 1'b0;
    tm("ovp retry", 0, 1'b1, 3 * HC, HC - 2, HC + 3);
    $display("test short and ovp done");
    i_temp <= hot;
    tm("at limit", 0, 1'b0, 10, 10, 10);
    i_temp <= hot + 8'h01;
    tm("hot off", 0, 1'b0, 3, 2, 2);
    i_temp <= hot - hys;
    tm("hys hold", 0, 1'b1, 5 * HC, 5 * HC, 5 * HC);
    i_temp <= hot - hys - 8'h01;
    tm("hot clear", 0, 1'b1, 3 * HC, 1, 2 * HC + 3);
    wreg(A_TLIM, regs[2] | 32'h0120_0000);
    i_temp <= 8'hFF;
    tm("hot ignored", 0, 1'b0, 10, 10, 10);
    i_temp <= 8'h10;
    tm("cold off", 0, 1'b0, 3, 2, 2);
    i_temp <= 8'h40;
    tm("cold clear", 0, 1'b1, 3 * HC, 1, 2 * HC + 3);
    $display("test thermal done");
    i_vin_below_uv <= 1'b1;
    i_vin_above_start <= 1'b0;
    tm("uv off", 0, 1'b0, 3, 2, 2);
    i_vin_below_uv <= 1'b0;
    tm("uv lock", 0, 1'b1, 3 * RC, 3 * RC, 3 * RC);
    i_vin_above_start <= 1'b1;
    tm("uv restart", 0, 1'b1, 4 * RC, RC, 2 * RC + 4);
    $display("test undervoltage done");
    conclude;
  end
endmodule // tb
